// [hw/crbr_pin_cell.sv]
`timescale 1ns/1ps
module crbr_pin_cell
    import crbr_pkg::*;
(
    input wire crbr_src_t sel,
    input wire logic [CRBR_NUM_SRC-1:0] src_val,
    input wire logic port_latch,
    input wire logic digital_mode,
    input wire logic push_pull,
    input wire logic pullup_disable,
    output logic pad_out,
    output logic pad_oe,
    output logic pullup_en
);

    logic drive_val;
    logic drives;

    // Unrouted pins fall back to the port latch, like a plain GPIO
    always_comb begin
        drive_val = (sel == CRBR_SRC_NONE) ? port_latch : src_val[sel];
        drives = digital_mode && !crbr_src_is_input(sel);
        if (!drives) begin
            pad_out = 1'b0;
            pad_oe = 1'b0;
        end else if (push_pull) begin
            pad_out = drive_val;
            pad_oe = 1'b1;
        end else begin
            // Open drain only ever pulls low; the pull-up gives the high
            pad_out = 1'b0;
            pad_oe = !drive_val;
        end
    end

    // Analog pins never get the pull-up, whatever software asks
    assign pullup_en = !pullup_disable && digital_mode;  // [RULE1]

endmodule

// [hw/crbr_pkg.sv]
package crbr_pkg;

    // Register location on the special-function-register bus
    localparam logic [7:0] CRBR_CFG2_ADDR = 8'hC7;
    localparam logic [7:0] CRBR_CFG2_PAGE = 8'h0F;
    localparam logic [7:0] CRBR_CFG2_RESET = 8'h00;

    // Field positions in crossbar_config_two
    localparam int CRBR_PULLUP_DISABLE_BIT = 7;
    localparam int CRBR_MATRIX_ENABLE_BIT = 6;
    localparam int CRBR_RSVD_HI_BIT = 5;
    localparam int CRBR_RSVD_LO_BIT = 4;
    localparam int CRBR_CMP2_ASYNC_EN_BIT = 3;
    localparam int CRBR_CMP2_EN_BIT = 2;
    localparam int CRBR_UART_B_EN_BIT = 1;
    localparam int CRBR_LIN_EN_BIT = 0;

    // Peripheral signals the crossbar can place on a pin, in priority order
    typedef enum logic [2:0] {
        CRBR_SRC_NONE = 3'b000,
        CRBR_SRC_UART_TX = 3'b001,
        CRBR_SRC_UART_RX = 3'b010,
        CRBR_SRC_CMP_SYNC = 3'b011,
        CRBR_SRC_CMP_ASYNC = 3'b100,
        CRBR_SRC_LIN_TX = 3'b101,
        CRBR_SRC_LIN_RX = 3'b110
    } crbr_src_t;

    localparam int CRBR_NUM_SRC = 7;

    // Receive sources leave the pad undriven and listen to it
    function automatic logic crbr_src_is_input(input crbr_src_t s);
        crbr_src_is_input = (s == CRBR_SRC_UART_RX) || (s == CRBR_SRC_LIN_RX);
    endfunction

endpackage

// [hw/crbr_route.sv]
`timescale 1ns/1ps
// Overview of operation
// RULE1: Weak pull-ups are on for every digital pin while pullup_disable is 0 and off everywhere when it is 1.
// RULE2: routing_matrix_enable gates all peripheral routing; at 0 no peripheral signal reaches a pin.
// RULE3: Software writes zero to reserved bits 5:4, which are kept as plain read/write bits resetting to zero.
// RULE4: The unclocked comparator-2 output reaches a pin only while comparator2_async_out_en is 1.
// RULE5: The clocked comparator-2 output reaches a pin only while comparator2_out_en is 1.
// RULE6: The second UART transmit and receive lines reach pins only while uart_b_route_en is 1.
// RULE7: The LIN transmit and receive lines reach pins only while lin_route_en is 1.
module crbr_route
    import crbr_pkg::*;
#(
    parameter int NUM_PINS = 8
)
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_page,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic uart_b_tx,
    output logic uart_b_rx,
    input wire logic comparator_two_output,
    input wire logic comparator_two_async,
    input wire logic lin_tx_line,
    output logic lin_rx_line,
    input wire logic [NUM_PINS-1:0] pin_in,
    input wire logic [NUM_PINS-1:0] pin_skip,
    input wire logic [NUM_PINS-1:0] pin_digital,
    input wire logic [NUM_PINS-1:0] pin_push_pull,
    input wire logic [NUM_PINS-1:0] pin_latch,
    output logic [NUM_PINS-1:0] pin_out,
    output logic [NUM_PINS-1:0] pin_oe,
    output logic [NUM_PINS-1:0] pin_pullup_en,
    output logic crossbar_enabled
);

    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] rdata;
    } crbr_state_t;

    crbr_state_t state_q;
    crbr_state_t state_d;
    logic hit;
    logic [CRBR_NUM_SRC-1:0] src_en;
    logic [CRBR_NUM_SRC-1:0] src_val;
    crbr_src_t pin_sel [NUM_PINS];
    logic [NUM_PINS-1:0] taken;
    logic placed;

    // Every source shares one gate: the matrix enable and its own bit.
    // Keeping the matrix bit in the same term means a single write of bit 6
    // parks all routing at once, whatever the per-source bits still hold.
    function automatic logic crbr_gate(input logic [7:0] cfg, input int bit_pos);
        crbr_gate = cfg[CRBR_MATRIX_ENABLE_BIT] && cfg[bit_pos];
    endfunction

    // Level seen on the pad that carries a given receive source.
    // A receive line with no pad idles high, which a UART or LIN receiver
    // reads as an idle line rather than as a start bit or a break.
    function automatic logic crbr_rx_level(
        input crbr_src_t want,
        input crbr_src_t sel [NUM_PINS],
        input logic [NUM_PINS-1:0] pads
    );
        logic level;
        level = 1'b1;
        for (int p = 0; p < NUM_PINS; p++) begin
            if (sel[p] == want) begin
                level = pads[p];
            end
        end
        crbr_rx_level = level;
    endfunction

    // Register access
    // The register sits on one address of one page. A write with a
    // matching address and page replaces all eight bits in one edge;
    // the reserved pair is stored as ordinary bits and drives nothing,
    // so software that writes them non-zero only changes what it reads back.
    // Reads are captured into a holding register on the strobe edge.
    // The holding register keeps its value until the next read strobe,
    // so a slow reader can pick it up at any later cycle.
    // A read of any other address returns zero so that several slices of
    // the register file can be merged with a plain OR on the read path.
    // A write and a read in the same cycle return the old contents,
    // because the capture uses the registered value, not the next one.

    // Register is selected by address and page together
    assign hit = (sfr_addr == CRBR_CFG2_ADDR) && (sfr_page == CRBR_CFG2_PAGE);

    // Register update and read capture
    always_comb begin
        state_d = state_q;
        if (sfr_wr && hit) begin
            state_d.cfg = sfr_wdata;  // [RULE3]
        end
        if (sfr_rd) begin
            // Other addresses read zero so this slice can be OR-merged
            state_d.rdata = hit ? state_q.cfg : 8'h00;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= '{cfg: CRBR_CFG2_RESET, rdata: 8'h00};
        end else begin
            state_q <= state_d;
        end
    end

    assign sfr_rdata = state_q.rdata;
    assign crossbar_enabled = state_q.cfg[CRBR_MATRIX_ENABLE_BIT];

    // Per-source enables, all behind the matrix enable
    // Transmit and receive of one peripheral share a bit, so they always
    // are enabled or disabled as a pair, though too few free pins can still leave half a link.
    always_comb begin
        src_en = '0;
        src_en[CRBR_SRC_UART_TX] = crbr_gate(state_q.cfg, CRBR_UART_B_EN_BIT);  // [RULE2] [RULE6]
        src_en[CRBR_SRC_UART_RX] = crbr_gate(state_q.cfg, CRBR_UART_B_EN_BIT);  // [RULE2] [RULE6]
        src_en[CRBR_SRC_CMP_SYNC] = crbr_gate(state_q.cfg, CRBR_CMP2_EN_BIT);  // [RULE2] [RULE5]
        src_en[CRBR_SRC_CMP_ASYNC] = crbr_gate(state_q.cfg, CRBR_CMP2_ASYNC_EN_BIT);  // [RULE2] [RULE4]
        src_en[CRBR_SRC_LIN_TX] = crbr_gate(state_q.cfg, CRBR_LIN_EN_BIT);  // [RULE2] [RULE7]
        src_en[CRBR_SRC_LIN_RX] = crbr_gate(state_q.cfg, CRBR_LIN_EN_BIT);  // [RULE2] [RULE7]
    end

    // Output values offered to pins; the async comparator path is never clocked
    always_comb begin
        src_val = '0;
        src_val[CRBR_SRC_UART_TX] = uart_b_tx;
        src_val[CRBR_SRC_CMP_SYNC] = comparator_two_output;
        src_val[CRBR_SRC_CMP_ASYNC] = comparator_two_async;
        src_val[CRBR_SRC_LIN_TX] = lin_tx_line;
    end

    // Pin allocation
    // Sources are visited in the fixed priority order of the source enum:
    // UART transmit, UART receive, clocked comparator, unclocked comparator,
    // LIN transmit, LIN receive. Each enabled source takes the lowest pin
    // that is neither skipped nor already taken by a higher source.
    // Skipped pins are left to the port latch, so software can reserve a
    // pin for plain GPIO or analog use without moving any peripheral bit.
    // Turning a high-priority source on shifts every lower source up by
    // one pin; software must set the enables before it relies on a pinout.
    // A source that finds no free pin is dropped silently; there is no
    // status for it, which is a limit of this simple scheme.
    // The whole search is combinational and unrolls to a chain of
    // NUM_PINS times the source count; at the default size it is short,
    // but a much wider port would want a registered allocation instead.
    // The analog or digital mode of a pin does not take part in the
    // search: an analog pin may be handed a source and then simply not
    // drive it, which keeps the pinout independent of the mode registers.
    always_comb begin
        taken = '0;
        placed = 1'b0;
        for (int p = 0; p < NUM_PINS; p++) begin
            pin_sel[p] = CRBR_SRC_NONE;
        end
        for (int s = 1; s < CRBR_NUM_SRC; s++) begin
            placed = 1'b0;
            for (int p = 0; p < NUM_PINS; p++) begin
                if (src_en[s] && !placed && !taken[p] && !pin_skip[p]) begin
                    pin_sel[p] = crbr_src_t'(s[2:0]);
                    taken[p] = 1'b1;
                    placed = 1'b1;
                end
            end
        end
    end

    // Unrouted receive lines idle high so the peripherals see a quiet line
    assign uart_b_rx = crbr_rx_level(CRBR_SRC_UART_RX, pin_sel, pin_in);  // [RULE6]
    assign lin_rx_line = crbr_rx_level(CRBR_SRC_LIN_RX, pin_sel, pin_in);  // [RULE7]

    // Pad cells
    // One cell per pin turns the chosen source into drive level and
    // output enable, honouring push-pull or open-drain and analog mode.
    // The pull-up disable bit reaches every cell unchanged; the cell
    // itself keeps the pull-up off on analog pins.

    for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
        crbr_pin_cell u_cell (
            .sel(pin_sel[p]),
            .src_val(src_val),
            .port_latch(pin_latch[p]),
            .digital_mode(pin_digital[p]),
            .push_pull(pin_push_pull[p]),
            .pullup_disable(state_q.cfg[CRBR_PULLUP_DISABLE_BIT]),  // [RULE1]
            .pad_out(pin_out[p]),
            .pad_oe(pin_oe[p]),
            .pullup_en(pin_pullup_en[p])
        );
    end

endmodule

// [tb/crbr_route_monitor.sv]
`timescale 1ns/1ps
module crbr_route_monitor
    import crbr_pkg::*;
#(
    parameter int NUM_PINS = 8
)
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_page,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic uart_b_rx,
    input wire logic lin_rx_line,
    input wire logic [NUM_PINS-1:0] pin_digital,
    input wire logic [NUM_PINS-1:0] pin_pullup_en,
    input wire logic crossbar_enabled
);
    logic [7:0] shadow_q;
    logic hit;
    assign hit = sfr_addr == CRBR_CFG2_ADDR && sfr_page == CRBR_CFG2_PAGE;
    // Mirror of the register, so pin checks need no access to the design's state
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            shadow_q <= 8'h00;
        end else if (sfr_wr && hit) begin
            shadow_q <= sfr_wdata;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    sequence s_read; sfr_rd && hit; endsequence
    sequence s_write; sfr_wr && hit; endsequence
    property p_rd; s_read |=> sfr_rdata == $past(shadow_q); endproperty
    property p_pull; pin_pullup_en == (shadow_q[7] ? '0 : pin_digital); endproperty
    property p_xbar; !shadow_q[6] |-> !crossbar_enabled && uart_b_rx && lin_rx_line; endproperty
    property p_wr; s_write |=> crossbar_enabled == $past(sfr_wdata[6]); endproperty
    property p_uart; !shadow_q[1] |-> uart_b_rx; endproperty
    property p_lin; !shadow_q[0] |-> lin_rx_line; endproperty
    a_rd: assert property (p_rd)
        else $error("read data differs from stored value");
    a_pull: assert property (p_pull)
        else $error("pull-up enables wrong");
    a_xbar: assert property (p_xbar)
        else $error("routing active while matrix off");
    a_wr: assert property (p_wr)
        else $error("matrix enable did not follow write");
    a_uart: assert property (p_uart)
        else $error("uart receive routed while disabled");
    a_lin: assert property (p_lin)
        else $error("lin receive routed while disabled");
endmodule
bind crbr_route crbr_route_monitor #(.NUM_PINS(NUM_PINS)) crbr_route_monitor_inst (.mclk(mclk), .reset_n(reset_n),
    .sfr_addr(sfr_addr), .sfr_page(sfr_page), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .uart_b_rx(uart_b_rx), .lin_rx_line(lin_rx_line), .pin_digital(pin_digital),
    .pin_pullup_en(pin_pullup_en), .crossbar_enabled(crossbar_enabled));

// [tb/crossbar_route_enables_tb_top.sv]
`timescale 1ns/1ps
module crossbar_route_enables_tb_top;
    import crbr_pkg::*;
    logic mclk = 0, reset_n = 0, sfr_wr = 0, sfr_rd = 0, rd_seen;
    logic utx = 0, ltx = 0, cs = 0, ca = 0, urx, lrx, xen, erx;
    logic [7:0] sfr_addr = 0, sfr_page = 0, sfr_wdata = 0, sfr_rdata, po, pu, v, e, m, oe;
    logic [7:0] pin_in = 0, pin_latch = 0, pin_dig = 8'hFF;
    logic [7:0] exp_q[$];
    int error_cnt = 0, n_tests = 0, seed = 77, n;
    always #20 mclk = ~mclk;
    crbr_route #(.NUM_PINS(8)) crbr_route_inst (.mclk(mclk), .reset_n(reset_n), .sfr_addr(sfr_addr),
        .sfr_page(sfr_page), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .uart_b_tx(utx), .uart_b_rx(urx), .comparator_two_output(cs), .comparator_two_async(ca),
        .lin_tx_line(ltx), .lin_rx_line(lrx), .pin_in(pin_in), .pin_skip(8'h00), .pin_digital(pin_dig),
        .pin_push_pull(8'hFF), .pin_latch(pin_latch), .pin_out(po), .pin_oe(oe), .pin_pullup_en(pu),
        .crossbar_enabled(xen));
    task chk(input logic [7:0] seen, input logic [7:0] want);
        n_tests++;
        if (seen !== want) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task wrap_up;
        $display("errors=%0d checks=%0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // One strobe cycle; a read queues its expected byte for the watcher
    task acc(input logic w, input logic [7:0] a, input logic [7:0] p, input logic [7:0] d);
        @(posedge mclk) #1;
        sfr_wr = w;
        sfr_rd = !w;
        sfr_addr = a;
        sfr_page = p;
        sfr_wdata = d;
        if (!w) exp_q.push_back(d);
        @(posedge mclk) #1;
        sfr_wr = 0;
        sfr_rd = 0;
    endtask
    // Read data is registered, so look a little after the edge that follows the strobe
    always @(posedge mclk) begin
        rd_seen = sfr_rd;
        #2;
        if (rd_seen) chk(sfr_rdata, exp_q.pop_front());
    end
    // Watchdog sized well above the 64-pass sequence
    initial begin
        #60000;
        error_cnt++;
        wrap_up;
    end
    initial begin
        repeat (5) @(posedge mclk);
        #1 reset_n = 1;
        acc(0, CRBR_CFG2_ADDR, CRBR_CFG2_PAGE, 8'h00);
        acc(1, 8'hC6, CRBR_CFG2_PAGE, 8'hFF);
        acc(1, CRBR_CFG2_ADDR, 8'h0E, 8'hFF);
        acc(0, CRBR_CFG2_ADDR, CRBR_CFG2_PAGE, 8'h00);
        for (int k = 0; k < 64; k++) begin
            v = 8'($random(seed));
            pin_in = 8'($random(seed));
            pin_latch = 8'($random(seed));
            pin_dig = 8'($random(seed)) | 8'h7F;
            {cs, ca, utx, ltx} = 4'($random(seed));
            acc(1, CRBR_CFG2_ADDR, CRBR_CFG2_PAGE, v);
            acc(0, CRBR_CFG2_ADDR, CRBR_CFG2_PAGE, v);
            // Expected pad levels: receive pins are masked; the cell holds their drive level at 0 with the enable off
            e = pin_latch;
            m = 8'hFF;
            n = 0;
            erx = 1'b1;
            if (v[6] && v[1]) begin
                e[0] = utx;
                m[1] = 0;
                n = 2;
            end
            if (v[6] && v[2]) begin
                e[n] = cs;
                n++;
            end
            if (v[6] && v[3]) begin
                e[n] = ca;
                n++;
            end
            if (v[6] && v[0]) begin
                e[n] = ltx;
                m[n+1] = 0;
                erx = pin_in[n+1];
            end
            chk(po & m & pin_dig, e & m & pin_dig);
            chk(pu, v[7] ? 8'h00 : pin_dig);
            chk(oe, m & pin_dig);
            chk({6'h00, xen, urx}, {6'h00, v[6], v[6] && v[1] ? pin_in[1] : 1'b1});
            chk({7'h00, lrx}, {7'h00, erx});
        end
        wrap_up;
    end
endmodule
